// [src/tmw_pkg.sv]
package tmw_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam logic [7:0] OFF_GREG1  = 8'h0c;
  localparam logic [7:0] OFF_GREG2  = 8'h10;
  localparam logic [7:0] OFF_GREG3  = 8'h14;
  localparam logic [7:0] OFF_GREG4  = 8'h18;
  localparam logic [7:0] OFF_CAPSEL = 8'h1c;
  localparam logic [7:0] OFF_ISTAT  = 8'h20;
  localparam logic [7:0] OFF_ICLR   = 8'h24;
  localparam logic [7:0] OFF_IEN    = 8'h28;

  // Field position and event count
  localparam int unsigned BIT_WRAP  = 4;
  localparam int unsigned NUM_EVT   = 5;

  // Clock select codes
  localparam logic [2:0] CKS_PHI    = 3'h0;
  localparam logic [2:0] CKS_DIV8   = 3'h3;

  // Reset values and the counter maximum
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] GREG_RST  = 16'hffff;
  localparam logic [3:0]  LEVEL_RST = 4'h0;

  typedef struct packed {
    logic run;
    logic rsv6;
    logic buffer_pair_hi;
    logic buffer_pair_lo;
    logic rsv3;
    logic pulse_mode_ch4;
    logic pulse_mode_ch3;
    logic pulse_mode_ch2;
  } tmw_mode_t;

  typedef struct packed {
    logic       clear_on_match_a;
    logic [2:0] clock_select_field;
    logic [3:0] out_level;
  } tmw_ctrl_t;

  // Reserved mode bits are held at one
  localparam tmw_mode_t MODE_RST = 8'h48;
  localparam tmw_ctrl_t CTRL_RST = 8'h00;

  typedef struct packed {
    logic [3:0] value;
    logic [3:0] drive;
  } tmw_chan_out_t;

endpackage

// [src/tmw_top.sv]
// The address map and register access over APB were chosen for this implementation.
module tmw_top #(
  parameter int unsigned AW = 8
) (
  // APB
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Pins
  input  wire logic          external_event_pin,
  input  wire logic          subclock_pin,
  input  wire logic          low_power_mode,
  input  wire logic [3:0]    channel_pin_in,
  output logic      [3:0]    channel_pin_out,
  output logic      [3:0]    channel_pin_oe,
  // Interrupt
  output logic               irq
);

  // Address decode needs at least the low byte
  if (AW < 8)
  begin : g_aw_check
    $error("tmw_top: AW must be at least 8");
  end

  // Synchronisers: first stage feeds only the second
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  logic [6:0] sync3_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      sync3_r <= 7'h00;
    end
    else
    begin
      sync1_r <= {low_power_mode, subclock_pin, external_event_pin, channel_pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire [3:0] pin_rise = sync2_r[3:0] & ~sync3_r[3:0];
  wire       ext_rise = sync2_r[4] & ~sync3_r[4];
  wire       sub_rise = sync2_r[5] & ~sync3_r[5];
  wire       lp_mode  = sync2_r[6];

  // Registers
  tmw_pkg::tmw_mode_t     mode_r;
  tmw_pkg::tmw_ctrl_t     ctrl_r;
  tmw_pkg::tmw_chan_out_t chan_r;
  logic [15:0]            count_r;
  logic [15:0]            greg_r [4];
  logic [3:0]             capsel_r;
  logic [4:0]             istat_r;
  logic [4:0]             ien_r;
  logic [2:0]             presc_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   irq_r;
  logic [31:0]            prdata_r;

  // APB decode; writes land on the edge that completes the transfer
  wire       acc_cyc  = psel & penable;
  wire       do_wr    = acc_cyc & pready_r & pwrite;
  wire [7:0] addr     = paddr[7:0];
  wire       hi_zero  = (paddr >> 8) == '0;
  wire       wr_mode  = do_wr & hi_zero & (addr == tmw_pkg::OFF_MODE);
  wire       wr_ctrl  = do_wr & hi_zero & (addr == tmw_pkg::OFF_CTRL);
  wire       wr_count = do_wr & hi_zero & (addr == tmw_pkg::OFF_COUNT);
  wire       wr_cap   = do_wr & hi_zero & (addr == tmw_pkg::OFF_CAPSEL);
  wire       wr_iclr  = do_wr & hi_zero & (addr == tmw_pkg::OFF_ICLR);
  wire       wr_ien   = do_wr & hi_zero & (addr == tmw_pkg::OFF_IEN);
  wire [3:0] wr_greg  = {4{do_wr & hi_zero}} & {addr == tmw_pkg::OFF_GREG4, addr == tmw_pkg::OFF_GREG3,
                                                addr == tmw_pkg::OFF_GREG2, addr == tmw_pkg::OFF_GREG1};

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = hi_zero;
    unique case (addr)
      tmw_pkg::OFF_MODE:   rd_mux = {24'h000000, mode_r};
      tmw_pkg::OFF_CTRL:   rd_mux = {24'h000000, ctrl_r};
      tmw_pkg::OFF_COUNT:  rd_mux = {16'h0000, count_r};
      tmw_pkg::OFF_GREG1:  rd_mux = {16'h0000, greg_r[0]};
      tmw_pkg::OFF_GREG2:  rd_mux = {16'h0000, greg_r[1]};
      tmw_pkg::OFF_GREG3:  rd_mux = {16'h0000, greg_r[2]};
      tmw_pkg::OFF_GREG4:  rd_mux = {16'h0000, greg_r[3]};
      tmw_pkg::OFF_CAPSEL: rd_mux = {28'h0000000, capsel_r};
      tmw_pkg::OFF_ISTAT:  rd_mux = {27'h0000000, istat_r};
      tmw_pkg::OFF_ICLR:   rd_mux = 32'h00000000;
      tmw_pkg::OFF_IEN:    rd_mux = {27'h0000000, ien_r};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Count clock selection; prescaler runs free so a divide change can slip one tick
  wire [2:0] cks      = ctrl_r.clock_select_field;
  wire [2:0] div_mask = 3'((4'h1 << cks[1:0]) - 4'h1);
  wire       presc_hit = (presc_r & div_mask) == div_mask;
  wire       phi_tick = lp_mode ? sub_rise : 1'b1;
  wire       src_tick = cks[2] ? ext_rise
                      : (cks == tmw_pkg::CKS_PHI) ? phi_tick : presc_hit;
  wire       tick     = mode_r.run & src_tick;

  // Channels three/four lose their own compare and capture while buffering
  wire [3:0] own_func = {~mode_r.buffer_pair_hi, ~mode_r.buffer_pair_lo, 2'b11};
  wire [3:0] is_match;
  wire [3:0] is_capt  = own_func & capsel_r & pin_rise;
  wire [3:0] pwm_sel  = {mode_r.pulse_mode_ch4, mode_r.pulse_mode_ch3, mode_r.pulse_mode_ch2, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_cmp
      assign is_match[g] = tick & own_func[g] & ~capsel_r[g] & (count_r == greg_r[g]);
    end
  endgenerate

  // Clear has priority, so a count write in the matching cycle is lost
  wire clr_cnt = is_match[0] & ctrl_r.clear_on_match_a;
  wire wrap    = tick & ~clr_cnt & ~wr_count & (count_r == tmw_pkg::COUNT_MAX);

  // Counter: clear beats a software write, which beats a tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= tmw_pkg::COUNT_RST;
    else if (clr_cnt)
      count_r <= tmw_pkg::COUNT_RST;
    else if (wr_count)
      count_r <= pwdata[15:0];
    else if (tick)
      count_r <= count_r + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc_r <= 3'h0;
    else
      presc_r <= presc_r + 3'h1;
  end

  // Mode and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r   <= tmw_pkg::MODE_RST;
      ctrl_r   <= tmw_pkg::CTRL_RST;
      capsel_r <= 4'h0;
      ien_r    <= 5'h00;
    end
    else
    begin
      if (wr_mode)
        mode_r <= pwdata[7:0] | tmw_pkg::MODE_RST;
      if (wr_ctrl)
        ctrl_r <= pwdata[7:0];
      if (wr_cap)
        capsel_r <= pwdata[3:0];
      if (wr_ien)
        ien_r <= pwdata[4:0];
    end
  end

  // General registers with capture and buffer transfer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        greg_r[i] <= tmw_pkg::GREG_RST;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wr_greg[i])
          greg_r[i] <= pwdata[15:0];
        else if (is_capt[i])
          greg_r[i] <= count_r;
      end
      // Buffer transfer comes last, so a match overrides a software write
      for (int i = 0; i < 2; i++)
      begin
        if (!own_func[i+2] && is_match[i])
          greg_r[i] <= greg_r[i+2];
        else if (!own_func[i+2] && is_capt[i])
          greg_r[i+2] <= greg_r[i];
      end
    end
  end

  // Pin outputs; a level write overrides any event in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_r.value <= tmw_pkg::LEVEL_RST;
      chan_r.drive <= 4'h0;
    end
    else
    begin
      chan_r.drive <= ~capsel_r;
      for (int i = 0; i < 4; i++)
      begin
        if (wr_ctrl)
          chan_r.value[i] <= pwdata[i];
        else if (pwm_sel[i] && is_match[i])
          chan_r.value[i] <= 1'b0;
        else if (pwm_sel[i] && is_match[0])
          chan_r.value[i] <= 1'b1;
        else if (!pwm_sel[i] && is_match[i])
          chan_r.value[i] <= ~chan_r.value[i];
      end
    end
  end

  // Interrupt status: set wins over clear
  wire [4:0] evt = {wrap, is_match | is_capt};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      istat_r <= 5'h00;
      irq_r   <= 1'b0;
    end
    else
    begin
      istat_r <= evt | (istat_r & ~({5{wr_iclr}} & pwdata[4:0]));
      irq_r   <= |((evt | (istat_r & ~({5{wr_iclr}} & pwdata[4:0]))) & ien_r);
    end
  end

  // APB answer: ready on the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
    else
    begin
      pready_r  <= acc_cyc & ~pready_r;
      pslverr_r <= acc_cyc & ~pready_r & ~rd_hit;
      if (acc_cyc && !pready_r && !pwrite)
        prdata_r <= rd_mux;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign channel_pin_out = chan_r.value;
  assign channel_pin_oe  = chan_r.drive;
  assign irq             = irq_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A divide-by-eight tick is followed by seven quiet cycles; a select change is not judged
  sequence div8_gap;
    (!tick || cks != tmw_pkg::CKS_DIV8) [*7] ##1 (tick || cks != tmw_pkg::CKS_DIV8 || !mode_r.run);
  endsequence

  sequence level_written;
    wr_ctrl ##1 1'b1;
  endsequence

  AST_STOPPED: assert property (!mode_r.run && !wr_count |=> count_r == $past(count_r))
    else $error("counter moved while stopped");
  AST_BUF_HI: assert property (mode_r.buffer_pair_hi && is_match[1] && !wr_greg[1]
                               |=> greg_r[1] == $past(greg_r[3]))
    else $error("register two not loaded from its buffer");
  AST_BUF_LO: assert property (mode_r.buffer_pair_lo && is_match[0] && !wr_greg[0]
                               |=> greg_r[0] == $past(greg_r[2]))
    else $error("register one not loaded from its buffer");
  AST_PWM_LOW: assert property (mode_r.pulse_mode_ch2 && is_match[1] && !wr_ctrl
                                |=> !chan_r.value[1])
    else $error("pwm channel two not low after its match");
  AST_CH1_TOGGLE: assert property (is_match[0] && !wr_ctrl
                                   |=> chan_r.value[0] != $past(chan_r.value[0]))
    else $error("channel one did not toggle on match");
  AST_CAPTURE: assert property (is_capt[2] && !wr_greg[2] && !(is_capt[0] && mode_r.buffer_pair_lo)
                                |=> greg_r[2] == $past(count_r))
    else $error("capture value wrong");
  AST_CLEAR: assert property (clr_cnt |=> count_r == tmw_pkg::COUNT_RST)
    else $error("counter not cleared on match");
  AST_DIV8: assert property (tick && cks == tmw_pkg::CKS_DIV8
                             |=> div8_gap)
    else $error("divide by eight spacing wrong");
  AST_EXT: assert property (mode_r.run && cks[2] && ext_rise && !wr_count && !clr_cnt
                            |=> count_r == $past(count_r) + 16'h0001)
    else $error("external edge not counted");
  AST_SUBCLK: assert property (mode_r.run && cks == tmw_pkg::CKS_PHI && lp_mode && !sub_rise
                               && !wr_count && !clr_cnt |=> count_r == $past(count_r))
    else $error("counted without subclock edge");
  AST_LEVEL: assert property (level_written |-> chan_r.value == $past(pwdata[3:0]))
    else $error("output level not applied");
  AST_RSV: assert property (mode_r.rsv6 && mode_r.rsv3)
    else $error("reserved mode bits not one");
  AST_WRAP: assert property (wrap |=> count_r == tmw_pkg::COUNT_RST && istat_r[tmw_pkg::BIT_WRAP])
    else $error("wrap not flagged");

endmodule

// [sim/timer_mode_and_control_bench.sv]
module timer_mode_and_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_pin    = 1'b0;
  logic        sub_pin    = 1'b0;
  logic        low_pwr    = 1'b0;
  logic [3:0]  pin_in     = 4'h0;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic        irq;
  logic [2:0]  slow_cnt   = 3'h0;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  logic        err;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          highs [4];
  logic [3:0]  lvl [4]    = '{4'h5, 4'ha, 4'hf, 4'h0};
  logic [2:0]  cks [8]    = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0, 3'h1};
  logic        lp [8]     = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  logic [31:0] step [8]   = '{32'h28, 32'h14, 32'ha, 32'h5, 32'h4, 32'h4, 32'h4, 32'h14};

  always #4 pclk = ~pclk;

  // Slow sources with a 10-cycle period, so a 40-cycle window always holds exactly four rising edges
  always @(posedge pclk)
  begin
    if (slow_cnt == 3'h4)
    begin
      slow_cnt <= 3'h0;
      ext_pin  <= ~ext_pin;
      sub_pin  <= ~sub_pin;
    end
    else
      slow_cnt <= slow_cnt + 3'h1;
  end

  tmw_top i_dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .external_event_pin (ext_pin),
    .subclock_pin       (sub_pin),
    .low_power_mode     (low_pwr),
    .channel_pin_in     (pin_in),
    .channel_pin_out    (pin_out),
    .channel_pin_oe     (pin_oe),
    .irq                (irq)
  );

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q, err);
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_a);
    chk_word(what, exp, rd_a);
  endtask

  // Waits out one period first so a mode change has settled before sampling
  task automatic count_highs;
    highs = '{0, 0, 0, 0};
    repeat (10) @(posedge pclk);
    repeat (40)
    begin
      @(negedge pclk);
      foreach (highs[i]) highs[i] += int'(pin_out[i]);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("mode reset", tmw_pkg::OFF_MODE, 32'h48);
    rd_chk("ctrl reset", tmw_pkg::OFF_CTRL, 32'h0);
    chk_pin("oe reset", 4'hf, pin_oe);
    wr(tmw_pkg::OFF_MODE, 32'h37);
    rd_chk("mode reserved", tmw_pkg::OFF_MODE, 32'h7f);
    wr(tmw_pkg::OFF_MODE, 32'h0);
    rd_chk("mode cleared", tmw_pkg::OFF_MODE, 32'h48);
    foreach (lvl[i])
    begin
      wr(tmw_pkg::OFF_CTRL, {28'h0, lvl[i]});
      @(negedge pclk);
      chk_pin("out level", lvl[i], pin_out);
    end
    foreach (cks[i])
    begin
      wr(tmw_pkg::OFF_MODE, 32'h0);
      wr(tmw_pkg::OFF_CTRL, {25'h0, cks[i], 4'h0});
      low_pwr <= lp[i];
      wr(tmw_pkg::OFF_COUNT, 32'h0);
      rd_chk("stopped", tmw_pkg::OFF_COUNT, 32'h0);
      wr(tmw_pkg::OFF_MODE, 32'h80);
      rd(tmw_pkg::OFF_COUNT, rd_a);
      repeat (36) @(posedge pclk);
      rd(tmw_pkg::OFF_COUNT, rd_b);
      chk_word("rate", step[i], rd_b - rd_a);
    end
    low_pwr <= 1'b0;
    wr(tmw_pkg::OFF_MODE, 32'h0);
    wr(tmw_pkg::OFF_CTRL, 32'h0);
    wr(tmw_pkg::OFF_IEN, 32'h10);
    wr(tmw_pkg::OFF_COUNT, 32'hfff0);
    wr(tmw_pkg::OFF_MODE, 32'h80);
    repeat (30) @(posedge pclk);
    wr(tmw_pkg::OFF_MODE, 32'h0);
    rd_chk("status", tmw_pkg::OFF_ISTAT, 32'h1f);
    rd(tmw_pkg::OFF_COUNT, rd_a);
    chk_word("wrapped", 32'h1, {31'h0, rd_a < 32'h40});
    chk_pin("irq on", 4'h1, {3'h0, irq});
    wr(tmw_pkg::OFF_IEN, 32'h0);
    repeat (2) @(posedge pclk);
    chk_pin("irq masked", 4'h0, {3'h0, irq});
    wr(tmw_pkg::OFF_IEN, 32'h10);
    wr(tmw_pkg::OFF_ICLR, 32'h1f);
    rd_chk("status clear", tmw_pkg::OFF_ISTAT, 32'h0);
    chk_pin("irq cleared", 4'h0, {3'h0, irq});
    wr(tmw_pkg::OFF_COUNT, 32'h0);
    wr(tmw_pkg::OFF_GREG1, 32'h9);
    wr(tmw_pkg::OFF_GREG2, 32'h4);
    wr(tmw_pkg::OFF_CTRL, 32'h80);
    wr(tmw_pkg::OFF_MODE, 32'h81);
    rd(tmw_pkg::OFF_COUNT, rd_a);
    repeat (36) @(posedge pclk);
    rd(tmw_pkg::OFF_COUNT, rd_b);
    chk_word("period", rd_a, rd_b);
    chk_word("bounded", 32'h1, {31'h0, rd_b < 32'ha});
    count_highs();
    chk_word("pwm ch2", 32'd20, highs[1]);
    chk_word("normal ch3", 32'd0, highs[2]);
    chk_word("toggle ch1", 32'd20, highs[0]);
    wr(tmw_pkg::OFF_MODE, 32'h87);
    count_highs();
    chk_word("pwm ch3", 32'd40, highs[2]);
    chk_word("pwm ch4", 32'd40, highs[3]);
    wr(tmw_pkg::OFF_MODE, 32'h0);
    wr(tmw_pkg::OFF_GREG3, 32'h13);
    wr(tmw_pkg::OFF_GREG4, 32'h7);
    wr(tmw_pkg::OFF_GREG2, 32'h5);
    wr(tmw_pkg::OFF_MODE, 32'hb0);
    repeat (30) @(posedge pclk);
    rd_chk("buffer lo", tmw_pkg::OFF_GREG1, 32'h13);
    rd_chk("buffer hi", tmw_pkg::OFF_GREG2, 32'h7);
    apb(1'b0, 8'h30, 32'h0, rd_a, err);
    chk_word("unmapped", 32'h0, rd_a);
    chk_pin("slverr", 4'h1, {3'h0, err});
    wr(tmw_pkg::OFF_CAPSEL, 32'h1);
    // The drive enable follows the select one clock after the write lands
    @(posedge pclk);
    @(negedge pclk);
    chk_pin("capture oe", 4'he, pin_oe);
    wr(tmw_pkg::OFF_MODE, 32'h0);
    wr(tmw_pkg::OFF_COUNT, 32'h1234);
    wr(tmw_pkg::OFF_CAPSEL, 32'h5);
    pin_in <= 4'h5;
    repeat (6) @(posedge pclk);
    rd_chk("capture ch1", tmw_pkg::OFF_GREG1, 32'h1234);
    rd_chk("capture ch3", tmw_pkg::OFF_GREG3, 32'h1234);
    stop_test();
  end
endmodule
